// file: rtl/sfmc_top.v
/*
 * Fault handling and operating-mode control for a dual H-bridge stepper
 * driver with indexer position counter and interrupt status.
 * Assumes all inputs are synchronous to MCLK and the analog comparators
 * (temperature, supply lockout, overcurrent) arrive as clean levels.
 */
// How it works
// - Over-temperature: bridge off, fault flag low
// - Resume automatically once temperature safe
// - Release flag only after operation resumed
// - Supply lockout disables all, resets logic
// - Leave lockout only above rising threshold
// - Flag low throughout lockout, released after
// - Overcurrent: bridge off, retry after time
// - Active while sleep request high
// - Sleep: regulator off, bridge Hi-Z, indexer off
// - Sleep entered after sleep entry delay
// - Wait wake delay before outputs change
// - Enable high: bridge off, logic running
// - Steps still advance; shown on enable
// - Faults disable bridge; regulator per fault
`timescale 1ns/1ps
`include "sfmc_regs.vh"

module sfmc_top #(
  parameter POS_W = 8,
  parameter SLEEP_CYC = `SFMC_SLEEP_CYC,
  parameter WAKE_CYC = `SFMC_WAKE_CYC,
  parameter RETRY_CYC = `SFMC_RETRY_CYC,
  parameter CNT_W = 20
) (
  input wire MCLK,
  input wire RST,
  // Controller pins
  input wire SLEEP_REQUEST_N,
  input wire BRIDGE_ENABLE_N,
  input wire STEP,
  input wire DIR,
  // Analog condition levels, high while the condition holds
  input wire OVER_TEMP,
  input wire SUPPLY_BELOW_FALL,
  input wire SUPPLY_ABOVE_RISE,
  input wire OVER_CURRENT,
  // Register port
  input wire [3:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  // Open-drain fault flag: output is always 0, enable pulls low
  output reg FAULT_FLAG_N_O,
  output reg FAULT_FLAG_N_OE,
  // Power stage
  output reg BRIDGE_DRIVE,
  output reg BRIDGE_HIZ,
  output reg INTERNAL_REGULATOR_EN,
  output reg INDEXER_EN,
  output reg [POS_W-1:0] BRIDGE_POS,
  output reg [2:0] MODE_STATE,
  output reg IRQ
);

  // Register offsets
  localparam [3:0] A_STATUS = 4'h0;
  localparam [3:0] A_MASK = 4'h4;
  localparam [3:0] A_MODE = 4'h8;
  localparam [3:0] A_POS = 4'hc;

  // Power states
  localparam [1:0] S_LOCK = 2'h0;
  localparam [1:0] S_SLEEP = 2'h1;
  localparam [1:0] S_WAKE = 2'h2;
  localparam [1:0] S_RUN = 2'h3;

  reg [1:0] state_r; // Power state
  reg [1:0] state_nxt; // Next power state
  reg [CNT_W-1:0] cnt_r; // Sleep or wake delay counter
  reg [CNT_W-1:0] cnt_nxt; // Next delay count
  reg [CNT_W-1:0] retry_r; // Overcurrent retry counter
  reg ocp_r; // Overcurrent fault active
  reg therm_r; // Thermal fault active
  reg step_d_r; // Previous step level
  reg [POS_W-1:0] pos_r; // Indexer position
  reg [`SFMC_ST_W-1:0] status_r; // Sticky event bits
  reg [`SFMC_ST_W-1:0] mask_r; // Interrupt mask
  reg uv_d_r; // Previous lockout level, for event edge
  reg uv_pend_r; // Lockout seen and operation not yet resumed
  wire running; // Awake, out of lockout and wake delay
  wire [`SFMC_ST_W-1:0] ev; // Fault onset events
  wire fault_any; // Any fault condition active

  assign running = (state_r == S_RUN);
  // Lockout keeps the flag low through the wake delay that follows it
  assign fault_any = therm_r | ocp_r | uv_pend_r | (state_r == S_LOCK);
  assign ev = {~ocp_r & OVER_CURRENT & running, SUPPLY_BELOW_FALL & ~uv_d_r, OVER_TEMP & ~therm_r & running};

  // Power state transitions
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      S_LOCK:
      begin
        // Restart only above the rising threshold
        if (SUPPLY_ABOVE_RISE && !SUPPLY_BELOW_FALL)
        begin
          state_nxt = SLEEP_REQUEST_N ? S_WAKE : S_SLEEP;
          cnt_nxt = {CNT_W{1'b0}};
        end
      end
      S_SLEEP:
      begin
        // Raising the request starts the wake delay
        if (SLEEP_REQUEST_N)
        begin
          state_nxt = S_WAKE;
          cnt_nxt = {CNT_W{1'b0}};
        end
      end
      S_WAKE:
      begin
        // Outputs held until the wake delay ends
        if (!SLEEP_REQUEST_N)
        begin
          state_nxt = S_SLEEP;
        end
        else if (cnt_r >= WAKE_CYC[CNT_W-1:0] - 1'b1)
        begin
          state_nxt = S_RUN;
          cnt_nxt = {CNT_W{1'b0}};
        end
        else
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default:
      begin
        // Stay active while request high; sleep after entry delay
        if (SLEEP_REQUEST_N)
        begin
          cnt_nxt = {CNT_W{1'b0}};
        end
        else if (cnt_r >= SLEEP_CYC[CNT_W-1:0] - 1'b1)
        begin
          state_nxt = S_SLEEP;
          cnt_nxt = {CNT_W{1'b0}};
        end
        else
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
    endcase
    // Falling below lockout overrides everything
    if (SUPPLY_BELOW_FALL)
    begin
      state_nxt = S_LOCK;
      cnt_nxt = {CNT_W{1'b0}};
    end
  end

  // State and delay registers
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      state_r <= S_LOCK;
      cnt_r <= {CNT_W{1'b0}};
      // Reset starts in lockout, so no false lockout edge follows it
      uv_d_r <= 1'b1;
      uv_pend_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      uv_d_r <= SUPPLY_BELOW_FALL;
      // Held from lockout until the run state is reached
      if (state_r == S_LOCK)
        uv_pend_r <= 1'b1;
      else if (running)
        uv_pend_r <= 1'b0;
    end
  end

  // Thermal and overcurrent fault tracking
  always @(posedge MCLK)
  begin
    if (RST || state_r == S_LOCK || SUPPLY_BELOW_FALL)
    begin
      therm_r <= 1'b0;
      ocp_r <= 1'b0;
      retry_r <= {CNT_W{1'b0}};
    end
    else
    begin
      // Thermal fault clears on its own once safe
      therm_r <= OVER_TEMP;
      if (ocp_r)
      begin
        // Drive again after retry time, fault not latched
        if (retry_r >= RETRY_CYC[CNT_W-1:0] - 1'b1)
        begin
          ocp_r <= 1'b0;
          retry_r <= {CNT_W{1'b0}};
        end
        else
        begin
          retry_r <= retry_r + 1'b1;
        end
      end
      else if (OVER_CURRENT && running)
      begin
        ocp_r <= 1'b1;
      end
    end
  end

  // Indexer: advances on rising step while running, even if disabled
  always @(posedge MCLK)
  begin
    if (RST || state_r == S_LOCK)
    begin
      pos_r <= `SFMC_POS_RST;
      step_d_r <= 1'b0;
    end
    else
    begin
      step_d_r <= STEP;
      // Indexer frozen in sleep and wake; running with enable high
      if (running && STEP && !step_d_r)
      begin
        pos_r <= DIR ? pos_r - 1'b1 : pos_r + 1'b1;
      end
    end
  end

  // Output stage, all registered
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      FAULT_FLAG_N_O <= 1'b0;
      FAULT_FLAG_N_OE <= 1'b1;
      BRIDGE_DRIVE <= 1'b0;
      BRIDGE_HIZ <= 1'b1;
      INTERNAL_REGULATOR_EN <= 1'b0;
      INDEXER_EN <= 1'b0;
      BRIDGE_POS <= `SFMC_POS_RST;
      MODE_STATE <= `SFMC_MODE_LOCKOUT;
    end
    else
    begin
      FAULT_FLAG_N_O <= 1'b0;
      // Flag pulled while faulted; released once running again
      FAULT_FLAG_N_OE <= fault_any;
      // Bridge off for any fault, sleep, wake or enable high
      BRIDGE_DRIVE <= running && !fault_any && !BRIDGE_ENABLE_N;
      BRIDGE_HIZ <= !(running && !fault_any && !BRIDGE_ENABLE_N);
      // Regulator on unless sleeping or in lockout
      INTERNAL_REGULATOR_EN <= (state_r == S_WAKE) || running;
      INDEXER_EN <= running;
      // Position shown only while enable low
      if (!BRIDGE_ENABLE_N && running)
      begin
        BRIDGE_POS <= pos_r;
      end
      else if (state_r == S_LOCK)
      begin
        BRIDGE_POS <= `SFMC_POS_RST;
      end
      if (state_r == S_LOCK)
        MODE_STATE <= `SFMC_MODE_LOCKOUT;
      else if (state_r == S_SLEEP)
        MODE_STATE <= `SFMC_MODE_SLEEP;
      else if (state_r == S_WAKE)
        MODE_STATE <= `SFMC_MODE_WAKING;
      else if (fault_any)
        MODE_STATE <= `SFMC_MODE_FAULT;
      else if (BRIDGE_ENABLE_N)
        MODE_STATE <= `SFMC_MODE_DISABLED;
      else
        MODE_STATE <= `SFMC_MODE_OPERATING;
    end
  end

  // Interrupt status and mask; set wins over write-one clear
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      status_r <= {`SFMC_ST_W{1'b0}};
      mask_r <= `SFMC_MASK_RST;
      IRQ <= 1'b0;
    end
    else
    begin
      if (REG_WR && REG_ADDR == A_STATUS)
        status_r <= (status_r & ~REG_WDATA[`SFMC_ST_W-1:0]) | ev;
      else
        status_r <= status_r | ev;
      if (REG_WR && REG_ADDR == A_MASK)
        mask_r <= REG_WDATA[`SFMC_ST_W-1:0];
      IRQ <= |(status_r & mask_r);
    end
  end

  // Read data, one cycle after the read strobe
  always @(posedge MCLK)
  begin
    if (RST)
    begin
      REG_RDATA <= 32'h00000000;
    end
    else if (REG_RD)
    begin
      if (REG_ADDR == A_STATUS)
        REG_RDATA <= {29'h0, status_r};
      else if (REG_ADDR == A_MASK)
        REG_RDATA <= {29'h0, mask_r};
      else if (REG_ADDR == A_MODE)
        REG_RDATA <= {25'h0, therm_r, ocp_r, state_r == S_LOCK, 1'b0, state_r, 1'b0};
      else if (REG_ADDR == A_POS)
        REG_RDATA <= {{(32-POS_W){1'b0}}, pos_r};
      else
        REG_RDATA <= 32'h00000000;
    end
    else
    begin
      REG_RDATA <= 32'h00000000;
    end
  end

endmodule // sfmc_top

// file: rtl/sfmc_regs.vh
/*
 * Constants for the stepper fault and mode controller: timing figures,
 * mode field encodings, status bit positions and reset values.
 * Assumes a 125 MHz core clock; included by its bare name.
 */
`ifndef SFMC_REGS_VH
`define SFMC_REGS_VH

// Core clock period in picoseconds
`define SFMC_CLK_PS 8000
// Sleep entry delay in nanoseconds
`define SFMC_SLEEP_NS 1000
// Wake delay in nanoseconds
`define SFMC_WAKE_NS 1000000
// Overcurrent retry time in nanoseconds
`define SFMC_RETRY_NS 1000000
// Least times round up to whole cycles
`define SFMC_SLEEP_CYC ((`SFMC_SLEEP_NS * 1000 + `SFMC_CLK_PS - 1) / `SFMC_CLK_PS)
`define SFMC_WAKE_CYC ((`SFMC_WAKE_NS * 1000 + `SFMC_CLK_PS - 1) / `SFMC_CLK_PS)
`define SFMC_RETRY_CYC ((`SFMC_RETRY_NS * 1000 + `SFMC_CLK_PS - 1) / `SFMC_CLK_PS)

// Mode field encodings on MODE_STATE
`define SFMC_MODE_LOCKOUT 3'h0
`define SFMC_MODE_SLEEP 3'h1
`define SFMC_MODE_WAKING 3'h2
`define SFMC_MODE_OPERATING 3'h3
`define SFMC_MODE_DISABLED 3'h4
`define SFMC_MODE_FAULT 3'h5

// Status bit positions of the interrupt status and mask
`define SFMC_ST_THERM 0
`define SFMC_ST_UVLO 1
`define SFMC_ST_OCP 2
`define SFMC_ST_W 3

// Reset values
`define SFMC_POS_RST 8'h00
`define SFMC_MASK_RST 3'h0

`endif

// file: verif/sfmc_checker.sv
/* Assertions on the fault and mode controller ports.
   Assumes SLEEP_CYC 4, WAKE_CYC 20, RETRY_CYC 20. */
`timescale 1ns/1ps
module sfmc_checker #(
  parameter POS_W = 8
) (
  input wire MCLK,
  input wire RST,
  input wire SLEEP_REQUEST_N,
  input wire BRIDGE_ENABLE_N,
  input wire OVER_TEMP,
  input wire SUPPLY_BELOW_FALL,
  input wire OVER_CURRENT,
  input wire FAULT_FLAG_N_OE,
  input wire BRIDGE_DRIVE,
  input wire BRIDGE_HIZ,
  input wire INTERNAL_REGULATOR_EN,
  input wire INDEXER_EN,
  input wire [POS_W-1:0] BRIDGE_POS,
  input wire [2:0] MODE_STATE
);
  // One domain, reset quiets all checks
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  hiz_inverse_a:
    assert property (BRIDGE_HIZ == !BRIDGE_DRIVE) else $error("hiz not inverse of drive");
  temp_off_a:
    assert property (OVER_TEMP[*3] |=> !BRIDGE_DRIVE) else $error("bridge on while hot");
  temp_flag_a:
    assert property (MODE_STATE == 3'h3 && OVER_TEMP |-> ##[2:3] FAULT_FLAG_N_OE) else $error("flag idle when hot");
  lockout_a:
    assert property (SUPPLY_BELOW_FALL[*3] |=> !INTERNAL_REGULATOR_EN && BRIDGE_POS == 0 && FAULT_FLAG_N_OE)
      else $error("lockout not applied");
  sleep_out_a:
    assert property (MODE_STATE == 3'h1 && $past(MODE_STATE) == 3'h1 |-> !INTERNAL_REGULATOR_EN && !INDEXER_EN)
      else $error("sleep outputs wrong");
  sleep_delay_a:
    assert property ($fell(SLEEP_REQUEST_N) && MODE_STATE == 3'h3 |=> (MODE_STATE != 3'h1)[*3])
      else $error("sleep too early");
  wake_wait_a:
    assert property ($rose(SLEEP_REQUEST_N) && MODE_STATE == 3'h1 |=> (!BRIDGE_DRIVE)[*8]) else $error("early wake");
  retry_hold_a:
    assert property (MODE_STATE == 3'h3 && OVER_CURRENT |-> ##2 (!BRIDGE_DRIVE)[*8]) else $error("retry too short");
  enable_off_a:
    assert property (BRIDGE_ENABLE_N[*3] |=> !BRIDGE_DRIVE) else $error("bridge on while disabled");
endmodule // sfmc_checker
bind sfmc_top sfmc_checker #(.POS_W(POS_W)) chk_u (.MCLK(MCLK), .RST(RST), .SLEEP_REQUEST_N(SLEEP_REQUEST_N),
  .BRIDGE_ENABLE_N(BRIDGE_ENABLE_N), .OVER_TEMP(OVER_TEMP), .SUPPLY_BELOW_FALL(SUPPLY_BELOW_FALL),
  .OVER_CURRENT(OVER_CURRENT), .FAULT_FLAG_N_OE(FAULT_FLAG_N_OE), .BRIDGE_DRIVE(BRIDGE_DRIVE),
  .BRIDGE_HIZ(BRIDGE_HIZ), .INTERNAL_REGULATOR_EN(INTERNAL_REGULATOR_EN), .INDEXER_EN(INDEXER_EN),
  .BRIDGE_POS(BRIDGE_POS), .MODE_STATE(MODE_STATE));

// file: verif/sfmc_ctl_model.sv
/* Motor controller model: makes step pulses on request.
   Assumes go is driven synchronously to clk. */
`timescale 1ns/1ps
module sfmc_ctl_model (
  input wire clk,
  input wire go,
  input wire dir_in,
  output reg step,
  output reg dir
);
  // One step edge every two cycles while go is high
  initial step = 1'b0;
  initial dir = 1'b0;
  always @(posedge clk)
  begin
    step <= go & ~step;
    dir <= dir_in;
  end
endmodule // sfmc_ctl_model

// file: verif/tb_top.sv
/* Self-checking bench for the fault and mode controller.
   Assumes short counts: sleep 4, wake 20, retry 20 cycles. */
`timescale 1ns/1ps
module tb_top;
  reg mclk = 0, rst = 1, slp_n = 1, en_n = 0, ot = 0, bf = 1, ar = 0, oc = 0, wr = 0, rd = 0, go = 0, dr = 0;
  reg [3:0] ad = 0;
  reg [31:0] wd = 0, v;
  reg [7:0] p;
  wire [31:0] rdat;
  wire fo, foe, drv, hiz, ren, idx, irq, stp, dir;
  wire [7:0] pos;
  wire [2:0] mode;
  integer errors = 0, n_checks = 0;
  always #4 mclk = ~mclk;
  sfmc_ctl_model ctl_u (.clk(mclk), .go(go), .dir_in(dr), .step(stp), .dir(dir));
  sfmc_top #(.SLEEP_CYC(4), .WAKE_CYC(20), .RETRY_CYC(20)) dut_u (.MCLK(mclk), .RST(rst), .SLEEP_REQUEST_N(slp_n),
    .BRIDGE_ENABLE_N(en_n), .STEP(stp), .DIR(dir), .OVER_TEMP(ot), .SUPPLY_BELOW_FALL(bf), .SUPPLY_ABOVE_RISE(ar),
    .OVER_CURRENT(oc), .REG_ADDR(ad), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
    .FAULT_FLAG_N_O(fo), .FAULT_FLAG_N_OE(foe), .BRIDGE_DRIVE(drv), .BRIDGE_HIZ(hiz),
    .INTERNAL_REGULATOR_EN(ren), .INDEXER_EN(idx), .BRIDGE_POS(pos), .MODE_STATE(mode), .IRQ(irq));
  // Compare and count
  task ck(input [8*5:1] nm, input [31:0] e, input [31:0] s);
  begin
    n_checks = n_checks + 1;
    if (s !== e)
    begin
      errors = errors + 1;
      $display("BAD %0s exp %h got %h", nm, e, s);
    end
  end
  endtask
  task st(input integer n);
  begin
    repeat (n) @(posedge mclk);
    #1;
  end
  endtask
  // Bounded wait for a mode
  task wm(input [2:0] m);
    integer i;
  begin
    for (i = 0; i < 100 && mode !== m; i = i + 1)
      st(1);
  end
  endtask
  task wreg(input [3:0] a, input [31:0] d);
  begin
    @(posedge mclk);
    ad <= a; wd <= d; wr <= 1;
    @(posedge mclk);
    wr <= 0;
  end
  endtask
  task rreg(input [3:0] a);
  begin
    @(posedge mclk);
    ad <= a; rd <= 1;
    @(posedge mclk);
    rd <= 0;
    #1 v = rdat;
  end
  endtask
  task complete_run;
  begin
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // Power up through lockout
  task t_boot;
  begin
    ck("mode", 0, mode);
    ck("flag", 1, foe);
    ck("fo", 0, fo);
    @(posedge mclk);
    bf <= 0; ar <= 1;
    wm(3); st(2);
    ck("flag", 0, foe);
    ck("drv", 1, drv);
    rreg(4'h6); ck("unmap", 0, v);
  end
  endtask
  // Steps counted while bridge disabled
  task t_en;
  begin
    @(posedge mclk); en_n <= 1; st(3);
    ck("drv", 0, drv); ck("reg", 1, ren);
    p = pos;
    go <= 1; st(6); go <= 0; st(2);
    ck("pos", p, pos);
    en_n <= 0; st(3);
    ck("pos", p + 8'h03, pos);
    dr <= 1; go <= 1; st(6); go <= 0; st(3);
    ck("pos", p, pos);
  end
  endtask
  // Thermal shutdown and status interrupt
  task t_th;
  begin
    wreg(4'h4, 32'h1);
    ot <= 1; st(4);
    ck("drv", 0, drv); ck("flag", 1, foe);
    ck("reg", 1, ren);
    rreg(4'h0); ck("stat", 1, v[0]);
    ck("irq", 1, irq);
    ot <= 0; wm(3); st(2);
    ck("drv", 1, drv);
    ck("flag", 0, foe);
    wreg(4'h0, 32'h1); st(2);
    ck("irq", 0, irq);
  end
  endtask
  // Overcurrent with retry
  task t_oc;
  begin
    @(posedge mclk); oc <= 1;
    @(posedge mclk); oc <= 0; st(3);
    ck("drv", 0, drv); ck("flag", 1, foe);
    st(8); ck("drv", 0, drv);
    wm(3); st(2); ck("drv", 1, drv);
  end
  endtask
  // Sleep entry and wake
  task t_sl;
  begin
    @(posedge mclk); slp_n <= 0; st(2);
    ck("mode", 3, mode);
    wm(1); st(2);
    ck("reg", 0, ren); ck("hiz", 1, hiz); ck("idx", 0, idx);
    slp_n <= 1; st(5);
    ck("drv", 0, drv);
    wm(3); st(2); ck("drv", 1, drv);
  end
  endtask
  // Supply lockout and restart
  task t_lk;
  begin
    @(posedge mclk); bf <= 1; ar <= 0; st(4);
    ck("pos", 0, pos); ck("reg", 0, ren);
    bf <= 0; st(4);
    ck("mode", 0, mode);
    ar <= 1; st(5);
    ck("mode", 2, mode);
    ck("flag", 1, foe);
    wm(3); st(2);
    ck("flag", 0, foe);
  end
  endtask
  initial
  begin
    st(6);
    rst <= 0; st(1);
    t_boot; t_en; t_th; t_oc; t_sl; t_lk;
    complete_run;
  end
  initial
  begin
    #200000;
    errors = errors + 1;
    complete_run;
  end
endmodule // tb_top
